// File: logic/rfib_fault_bank.sv
/*
  rfib_fault_bank: fault sense and latched flags for the tail of bank 3
  and all of bank 4, mask and interrupt pin for bank 4, plus backup cell charger
  control. Assumes a synchronous byte-wide register port decoded from
  the serial control interface, and fault levels synchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none

// How it works
// R01: fuse error level reads live on bit 7 of bank-3 sense.
// R02: bank-3 sense bit 6 is high exactly while fuse burn runs.
// R03: host must not touch fuse test registers while bit 6 reads one.
// R04: boost overcurrent level reads live on bit 0 of bank-3 sense.
// R05: bank-4 status holds six flags: linreg4,3, 3v3, sd, linreg2,1.
// R06: each bank-4 flag sets while its regulator is in current limit.
// R07: writing one clears a flag; writing zero leaves it alone.
// R08: a zero mask bit lets its flag reach the interrupt pin.
// R09: a one mask bit blocks its flag; mask bits sit at 5 to 0.
// R10: bank-4 sense at 0x13 is read only and shows live levels.
// R11: bank-4 sense bits 7,6 read zero; others follow the regulators.
// R12: bank-4 sense bit is one while above limit, same positions.
// R13: charger control bit 3 switches the backup charger on or off.
// R14: charger control bits 2 to 0 pick the 2.50 to 3.30 V level.
// R15: bank-3 status bit 6 latches once the fuse burn has finished.
// R16: interrupt pin goes low while any unmasked flag is one.
// R17: sense writes are ignored; reserved bits read zero.
module rfib_fault_bank #(
  parameter int FAULT_N = rfib_pkg::FAULT_N
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // register port from the serial control interface
  input wire logic [rfib_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [rfib_pkg::DATA_W-1:0] i_reg_wdata,
  output var logic [rfib_pkg::DATA_W-1:0] o_reg_rdata,
  output var logic o_reg_rvalid,
  // live conditions from the analog side
  input wire logic i_fuse_error_sense,
  input wire logic i_fuse_burn_running_sense,
  input wire logic i_boost_overcurrent_sense,
  input wire logic [FAULT_N-1:0] i_rail_overcurrent_sense,
  // interrupt pin and charger controls
  output var logic o_irq_out_n,
  output var logic o_backup_charger_on,
  output var logic [rfib_pkg::VSEL_W-1:0] o_backup_charge_voltage_sel
);
  import rfib_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [FAULT_N-1:0] fault_status_bank4;
  logic [FAULT_N-1:0] fault_mask_bank4;
  logic [FAULT_N-1:0] next_mask;
  logic [FAULT_N-1:0] stat4_clear;
  logic fuse_burn_done_flag;
  logic done_clear;
  logic burn_running_q;
  logic next_burn_running_q;
  logic burn_finished;
  logic next_charger_on;
  logic [VSEL_W-1:0] next_vsel;
  logic [DATA_W-1:0] otp_boost_sense_bank3;
  logic [DATA_W-1:0] fault_sense_bank4;
  logic [DATA_W-1:0] next_rdata;
  logic next_rvalid;
  logic next_irq_n;
  logic wr_stat3;
  logic wr_stat4;
  logic wr_mask4;
  logic wr_coin;

  ////////////////////////////////////////////////////////////////////////
  // write decode; sense offsets have no write strobe at all
  // R17: sense writes dropped
  always_comb begin
    wr_stat3 = i_reg_wr && (i_reg_addr == OFS_STAT3);
    wr_stat4 = i_reg_wr && (i_reg_addr == OFS_STAT4);
    wr_mask4 = i_reg_wr && (i_reg_addr == OFS_MASK4);
    wr_coin = i_reg_wr && (i_reg_addr == OFS_CHG_CTL);
  end

  ////////////////////////////////////////////////////////////////////////
  // bank-4 latched fault flags, one cell per regulator
  genvar g;
  generate
    for (g = 0; g < FAULT_N; g++) begin : g_flag
      // R07: write one clears
      assign stat4_clear[g] = wr_stat4 & i_reg_wdata[g];
      // R06: current limit sets
      rfib_flag_cell u_cell (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_set(i_rail_overcurrent_sense[g]),
        .i_clear(stat4_clear[g]),
        .o_flag(fault_status_bank4[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // fuse burn completion: falling edge of the running level
  always_comb begin
    next_burn_running_q = i_fuse_burn_running_sense;
    // R15: end of burn sequence
    burn_finished = burn_running_q & ~i_fuse_burn_running_sense;
    done_clear = wr_stat3 & i_reg_wdata[BIT_FUSE_DONE];
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      burn_running_q <= 1'b0;
    end else begin
      burn_running_q <= next_burn_running_q;
    end
  end

  rfib_flag_cell u_done_cell (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_set(burn_finished),
    .i_clear(done_clear),
    .o_flag(fuse_burn_done_flag)
  );

  ////////////////////////////////////////////////////////////////////////
  // mask and charger control registers
  always_comb begin
    next_mask = fault_mask_bank4;
    next_charger_on = o_backup_charger_on;
    next_vsel = o_backup_charge_voltage_sel;
    // R09: mask bits 5 to 0
    if (wr_mask4) begin
      next_mask = i_reg_wdata[FAULT_N-1:0];
    end
    if (wr_coin) begin
      // R13: charger enable
      next_charger_on = i_reg_wdata[BIT_CHG_ON];
      // R14: voltage select
      next_vsel = i_reg_wdata[BIT_VSEL_LO +: VSEL_W];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fault_mask_bank4 <= RST_MASK4[FAULT_N-1:0];
      o_backup_charger_on <= RST_CHG_ON;
      o_backup_charge_voltage_sel <= RST_VSEL;
    end else begin
      fault_mask_bank4 <= next_mask;
      o_backup_charger_on <= next_charger_on;
      o_backup_charge_voltage_sel <= next_vsel;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // live sense images, reserved bits held at zero
  always_comb begin
    otp_boost_sense_bank3 = RD_ZERO;
    // R01: fuse error live
    otp_boost_sense_bank3[BIT_FUSE_ERR] = i_fuse_error_sense;
    // R02: burn running live
    otp_boost_sense_bank3[BIT_FUSE_RUN] = i_fuse_burn_running_sense;
    // R04: boost overcurrent live
    otp_boost_sense_bank3[BIT_BOOST_OC] = i_boost_overcurrent_sense;
    // R11: upper bits zero
    fault_sense_bank4 = RD_ZERO;
    // R12: same positions as flags
    fault_sense_bank4[FAULT_N-1:0] = i_rail_overcurrent_sense;
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux, answered one cycle after the strobe
  always_comb begin
    next_rdata = RD_ZERO;
    next_rvalid = i_reg_rd;
    if (i_reg_rd) begin
      case (i_reg_addr)
        OFS_STAT3: begin
          next_rdata[BIT_FUSE_DONE] = fuse_burn_done_flag;
        end
        OFS_SENSE3: begin
          next_rdata = otp_boost_sense_bank3;
        end
        // R05: six flags in order
        OFS_STAT4: begin
          next_rdata[FAULT_N-1:0] = fault_status_bank4;
        end
        OFS_MASK4: begin
          next_rdata[FAULT_N-1:0] = fault_mask_bank4;
        end
        // R10: live, read only
        OFS_SENSE4: begin
          next_rdata = fault_sense_bank4;
        end
        OFS_CHG_CTL: begin
          next_rdata[BIT_CHG_ON] = o_backup_charger_on;
          next_rdata[BIT_VSEL_LO +: VSEL_W] = o_backup_charge_voltage_sel;
        end
        default: begin
          next_rdata = RD_ZERO; // unmapped reads zero
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt pin, active low
  always_comb begin
    // R08: unmasked flags reach pin
    // R16: low while any unmasked
    next_irq_n = ~|(fault_status_bank4 & ~fault_mask_bank4);
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= RD_ZERO;
      o_reg_rvalid <= 1'b0;
      o_irq_out_n <= 1'b1;
    end else begin
      o_reg_rdata <= next_rdata;
      o_reg_rvalid <= next_rvalid;
      o_irq_out_n <= next_irq_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  irq_assert_a: assert property ( // R16
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (|(fault_status_bank4 & ~fault_mask_bank4)) |=> !o_irq_out_n)
    else $error("interrupt pin not asserted for unmasked flag");

  irq_masked_a: assert property ( // R09
    @(posedge i_sys_clk) disable iff (!i_resetn)
    ((fault_status_bank4 & ~fault_mask_bank4) == '0) |=> o_irq_out_n)
    else $error("interrupt pin low with all flags masked or clear");

  fault_to_irq_a: assert property ( // R08
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (i_rail_overcurrent_sense[0] && !fault_mask_bank4[0]
      && !wr_mask4) |=> ##1 !o_irq_out_n)
    else $error("unmasked fault did not reach the pin in two cycles");

  sense4_read_a: assert property ( // R10
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (i_reg_rd && i_reg_addr == OFS_SENSE4) |=>
      (o_reg_rvalid && o_reg_rdata[7:6] == 2'b00 &&
       o_reg_rdata[FAULT_N-1:0] == $past(i_rail_overcurrent_sense)))
    else $error("bank-4 sense read wrong");

  sense3_read_a: assert property ( // R02
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (i_reg_rd && i_reg_addr == OFS_SENSE3) |=>
      (o_reg_rdata[6] == $past(i_fuse_burn_running_sense) &&
       o_reg_rdata[7] == $past(i_fuse_error_sense) &&
       o_reg_rdata[0] == $past(i_boost_overcurrent_sense) &&
       o_reg_rdata[5:1] == 5'h00))
    else $error("bank-3 sense read wrong");

  burn_done_a: assert property ( // R15
    @(posedge i_sys_clk) disable iff (!i_resetn)
    ($fell(i_fuse_burn_running_sense) && burn_running_q) |=>
      fuse_burn_done_flag)
    else $error("fuse burn completion not latched");

  stat4_clear_a: assert property ( // R07
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (wr_stat4 && i_reg_wdata[3] && !i_rail_overcurrent_sense[3])
      |=> !fault_status_bank4[3])
    else $error("bank-4 flag not cleared by write of one");

  charger_write_a: assert property ( // R13
    @(posedge i_sys_clk) disable iff (!i_resetn)
    wr_coin |=> (o_backup_charger_on == $past(i_reg_wdata[3]) &&
      o_backup_charge_voltage_sel == $past(i_reg_wdata[2:0])))
    else $error("charger control write not applied");

  sense_write_a: assert property ( // R17
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (i_reg_wr && i_reg_addr == OFS_SENSE4) |=>
      ($stable(fault_mask_bank4) && $stable(o_backup_charger_on)))
    else $error("write to sense register changed state");

  rvalid_pulse_a: assert property ( // R10
    @(posedge i_sys_clk) disable iff (!i_resetn)
    !i_reg_rd |=> !o_reg_rvalid)
    else $error("read answer without a read strobe");

endmodule

`default_nettype wire

// File: shared/rfib_pkg.sv
/*
  rfib_pkg: shared constants of the regulator fault interrupt bank.
  Register offsets, field positions, widths and values after reset.
  Assumes an 8-bit register port from the serial control interface.
*/
`default_nettype none

package rfib_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int FAULT_N = 6;
  localparam int VSEL_W = 3;

  ////////////////////////////////////////////////////////////////////////
  // register offsets on the functional page
  localparam logic [7:0] OFS_STAT3 = 8'h0e;
  localparam logic [7:0] OFS_SENSE3 = 8'h10;
  localparam logic [7:0] OFS_STAT4 = 8'h11;
  localparam logic [7:0] OFS_MASK4 = 8'h12;
  localparam logic [7:0] OFS_SENSE4 = 8'h13;
  localparam logic [7:0] OFS_CHG_CTL = 8'h1a;

  ////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int BIT_FUSE_ERR = 7;
  localparam int BIT_FUSE_RUN = 6;
  localparam int BIT_FUSE_DONE = 6;
  localparam int BIT_BOOST_OC = 0;
  localparam int BIT_LINREG4 = 5;
  localparam int BIT_LINREG3 = 4;
  localparam int BIT_RAIL_3V3 = 3;
  localparam int BIT_SD_RAIL = 2;
  localparam int BIT_LINREG2 = 1;
  localparam int BIT_LINREG1 = 0;
  localparam int BIT_CHG_ON = 3;
  localparam int BIT_VSEL_LO = 0;

  ////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [5:0] RST_MASK4 = 6'h3f;
  localparam logic RST_CHG_ON = 1'b0;
  localparam logic [2:0] RST_VSEL = 3'h0;
  localparam logic [7:0] RD_ZERO = 8'h00;

endpackage

`default_nettype wire

// File: logic/rfib_flag_cell.sv
/*
  rfib_flag_cell: one latched event flag, cleared by a write of one.
  Assumes set and clear are single-cycle synchronous qualifiers.
*/
`timescale 1ns/1ps
`default_nettype none

module rfib_flag_cell (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // event and clear
  input wire logic i_set,
  input wire logic i_clear,
  // latched flag
  output var logic o_flag
);

  logic next_flag;

  // set beats a clear landing in the same cycle
  always_comb begin
    next_flag = i_set | (o_flag & ~i_clear);
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_flag <= 1'b0;
    end else begin
      o_flag <= next_flag;
    end
  end

  flag_set_wins_a: assert property ( // R06
    @(posedge i_sys_clk) disable iff (!i_resetn)
    i_set |=> o_flag)
    else $error("flag missed its set event");

  flag_clear_a: assert property ( // R07
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (!i_set && i_clear) |=> !o_flag)
    else $error("flag survived a clear");

  flag_hold_a: assert property ( // R07
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (!i_set && !i_clear) |=> $stable(o_flag))
    else $error("flag changed without cause");

endmodule

`default_nettype wire

// File: verification/rfib_host_model.sv
/*
  rfib_host_model: host side of the byte register port, standing in
  for the serial control master. Assumes the bench calls its tasks.
*/
`timescale 1ns/1ps
`default_nettype none

module rfib_host_model (
  // clock
  input wire logic i_sys_clk,
  // register port toward the bank
  output var logic [7:0] o_reg_addr,
  output var logic o_reg_wr,
  output var logic o_reg_rd,
  output var logic [7:0] o_reg_wdata,
  input wire logic [7:0] i_reg_rdata,
  input wire logic i_reg_rvalid
);
  // idle port values at time zero
  initial begin
    o_reg_addr = 8'h00;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_wdata = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // fuse test area: bank offsets are issued, plus one unmapped read at 8'h55
  // one-cycle write strobe, released lines show inverted values
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    o_reg_addr = a;
    o_reg_wdata = d;
    o_reg_wr = 1'b1;
    @(negedge i_sys_clk);
    o_reg_wr = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask

  // one-cycle read strobe, answer taken in the following cycle
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d,
      output logic v);
    @(negedge i_sys_clk);
    o_reg_addr = a;
    o_reg_rd = 1'b1;
    @(negedge i_sys_clk);
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
    d = i_reg_rdata;
    v = i_reg_rvalid;
  endtask
endmodule

`default_nettype wire

// File: verification/regulator_fault_interrupt_bank_tb.sv
/*
  regulator_fault_interrupt_bank_tb: self-checking bench for the fault
  bank. Assumes the host model drives the register port.
*/
`timescale 1ns/1ps
`default_nettype none

module regulator_fault_interrupt_bank_tb;
  import rfib_pkg::*;
  typedef struct packed {
    logic [5:0] rail;
    logic err, run, bst;
    logic [7:0] x4, x3;
  } rfib_row_s;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd, rvalid, v, irq_n, chg_on;
  logic ferr = 1'b0;
  logic frun = 1'b0;
  logic bst = 1'b0;
  logic [5:0] rail = 6'h00;
  logic [2:0] vsel;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  rfib_row_s rows [7] = '{
    '{6'h01, 1'b1, 1'b0, 1'b0, 8'h01, 8'h80},
    '{6'h02, 1'b0, 1'b1, 1'b0, 8'h02, 8'h40},
    '{6'h04, 1'b0, 1'b0, 1'b1, 8'h04, 8'h01},
    '{6'h08, 1'b0, 1'b0, 1'b0, 8'h08, 8'h00},
    '{6'h10, 1'b1, 1'b1, 1'b1, 8'h10, 8'hc1},
    '{6'h20, 1'b0, 1'b0, 1'b0, 8'h20, 8'h00},
    '{6'h3f, 1'b0, 1'b0, 1'b0, 8'h3f, 8'h00}};

  // clock
  always #2 sys_clk = ~sys_clk;

  rfib_fault_bank dut (.i_sys_clk(sys_clk), .i_resetn(resetn),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_fuse_error_sense(ferr), .i_fuse_burn_running_sense(frun),
    .i_boost_overcurrent_sense(bst), .i_rail_overcurrent_sense(rail),
    .o_irq_out_n(irq_n), .o_backup_charger_on(chg_on),
    .o_backup_charge_voltage_sel(vsel));

  rfib_host_model host (.i_sys_clk(sys_clk), .o_reg_addr(addr),
    .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_wdata(wdata),
    .i_reg_rdata(rdata), .i_reg_rvalid(rvalid));

  ////////////////////////////////////////////////////////////////////////
  // compare tasks and closing report
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host.rd_reg(a, d, v);
    chk1(v, 1'b1);
    chk8(d, e);
    // answer stands one cycle, then the port falls back to zero
    @(negedge sys_clk);
    chk1(rvalid, 1'b0);
    chk8(rdata, 8'h00);
  endtask

  task automatic print_verdict();
    $display("counts: compares=%0d mismatches=%0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (4) @(negedge sys_clk);
    resetn = 1'b1;
    foreach (rows[i]) begin
      @(negedge sys_clk);
      rail = rows[i].rail;
      ferr = rows[i].err;
      frun = rows[i].run;
      bst = rows[i].bst;
      rdchk(OFS_SENSE4, rows[i].x4);
      rdchk(OFS_SENSE3, rows[i].x3);
    end
    rdchk(OFS_STAT4, 8'h3f);
    chk1(irq_n, 1'b1);
    $display("test sense rows done");
    // move mask and charger off their reset values so reset is seen
    host.wr_reg(OFS_MASK4, 8'h00);
    host.wr_reg(OFS_CHG_CTL, 8'h0f);
    @(negedge sys_clk);
    chk1(irq_n, 1'b0);
    resetn = 1'b0;
    rail = 6'h00;
    @(negedge sys_clk);
    chk1(irq_n, 1'b1);
    chk8(rdata, 8'h00);
    @(negedge sys_clk);
    resetn = 1'b1;
    rdchk(OFS_MASK4, 8'h3f);
    rdchk(OFS_STAT4, 8'h00);
    rdchk(OFS_CHG_CTL, 8'h00);
    rdchk(OFS_STAT3, 8'h00);
    $display("test reset done");
    rail = 6'h06;
    @(negedge sys_clk);
    rail = 6'h00;
    repeat (2) @(negedge sys_clk);
    chk1(irq_n, 1'b1);
    host.wr_reg(OFS_STAT4, 8'h00);
    rdchk(OFS_STAT4, 8'h06);
    host.wr_reg(OFS_MASK4, 8'h3d);
    repeat (2) @(negedge sys_clk);
    chk1(irq_n, 1'b0);
    rail = 6'h02;
    host.wr_reg(OFS_STAT4, 8'h02);
    rdchk(OFS_STAT4, 8'h06);
    rail = 6'h00;
    host.wr_reg(OFS_STAT4, 8'h02);
    rdchk(OFS_STAT4, 8'h04);
    chk1(irq_n, 1'b1);
    host.wr_reg(OFS_MASK4, 8'h3b);
    repeat (2) @(negedge sys_clk);
    chk1(irq_n, 1'b0);
    host.wr_reg(OFS_MASK4, 8'hff);
    repeat (2) @(negedge sys_clk);
    chk1(irq_n, 1'b1);
    rdchk(OFS_MASK4, 8'h3f);
    $display("test flags and mask done");
    for (int c = 0; c < 8; c++) begin
      host.wr_reg(OFS_CHG_CTL, {5'h01, c[2:0]});
      chk1(chg_on, 1'b1);
      chk8({5'h00, vsel}, {5'h00, c[2:0]});
    end
    rdchk(OFS_CHG_CTL, 8'h0f);
    host.wr_reg(OFS_CHG_CTL, 8'hf5);
    chk1(chg_on, 1'b0);
    rdchk(OFS_CHG_CTL, 8'h05);
    $display("test charger done");
    frun = 1'b1;
    @(negedge sys_clk);
    frun = 1'b0;
    repeat (2) @(negedge sys_clk);
    rdchk(OFS_STAT3, 8'h40);
    host.wr_reg(OFS_STAT3, 8'h00);
    rdchk(OFS_STAT3, 8'h40);
    host.wr_reg(OFS_STAT3, 8'h40);
    rdchk(OFS_STAT3, 8'h00);
    $display("test fuse done flag done");
    // unmasked bit 0 pulse reaches the pin; bulk clear covers bit 3
    host.wr_reg(OFS_MASK4, 8'h3e);
    rail = 6'h09;
    @(negedge sys_clk);
    rail = 6'h00;
    @(negedge sys_clk);
    chk1(irq_n, 1'b0);
    rdchk(OFS_STAT4, 8'h0d);
    host.wr_reg(OFS_STAT4, 8'h3f);
    rdchk(OFS_STAT4, 8'h00);
    chk1(irq_n, 1'b1);
    $display("test bulk clear done");
    host.wr_reg(OFS_SENSE4, 8'hff);
    host.wr_reg(OFS_SENSE3, 8'hff);
    rdchk(OFS_SENSE4, 8'h00);
    rdchk(OFS_SENSE3, 8'h00);
    rdchk(8'h55, 8'h00);
    $display("test refusals done");
    print_verdict();
  end
endmodule

`default_nettype wire
